// File: hw/pm_ctl.sv
// power management control register with phy reset and wake status
//
// Overview of operation
// - writing one to phy reset starts reset
// - phy reset held at least 4 ms
// - request bit self-clears when phy leaves reset
// - writes to request ignored while it reads one
// - ready drops on request, returns when phy operational
// - skip-analog setting selects the 4 ms hold; cleared, the hold is 128 ms
// - lan wake enable admits lan wake events
// - phy irq wake enable admits phy interrupt
// - remote resume clears enables when option set
// - status bits clear on write of one
// - low bit phy wake, high bit lan wake
// - energy wake status per suspend state
// - several status bits may be set together
// - no wake cause status without prior enable
// - remote resume clears upper status when option set
// - crystal bit restored from image on usb and lite soft resets
// - suspend mode field selects states 0..3
// - host resumes leave enables untouched
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`include "pm_ctl_regs.svh"
module pm_ctl #(
    parameter int SHORT_CYC = `PMC_MS_CYCLES(`PMC_PHY_RESET_REQUEST_MIN_MS),
    parameter int LONG_CYC  = `PMC_MS_CYCLES(`PMC_PHY_RESET_REQUEST_LONG_MS)
) (
    // clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // avalon-mm slave
    input  wire logic [`PMC_ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic                   AVS_READ,
    input  wire logic                   AVS_WRITE,
    input  wire logic [31:0]            AVS_WRITEDATA,
    output logic [31:0]                 AVS_READDATA,
    output logic                        AVS_WAITREQUEST,
    // phy
    output logic                        PHY_RESET,
    input  wire logic                   PHY_OPERATIONAL,
    // wake events, one-cycle pulses
    input  wire logic                   PHY_WAKE_EVT,
    input  wire logic                   LAN_WAKE_EVT,
    input  wire logic                   ENERGY_EFF_RX_WAKE,
    input  wire logic                   ENERGY_EFF_TX_WAKE,
    // power unit
    input  wire logic                   RESUME_DONE,
    input  wire logic                   RESUME_REMOTE,
    input  wire logic                   LITE_SOFT_RESET,
    input  wire logic                   USB_RESET,
    input  wire logic                   IMAGE_VALID,
    input  wire logic                   IMAGE_XTAL_DIS,
    output logic [1:0]                  SUSPEND_SEL,
    output logic                        DEVICE_READY,
    output logic                        LAN_WAKE_ARMED,
    output logic                        PHY_WAKE_ARMED,
    output logic                        CRYSTAL_SUSPEND_DISABLE
);
    logic       wr_stb;
    logic       ctrl_wr;
    logic       cfg_wr;
    logic [31:0] wd;
    logic       waitrequest;

    logic       phy_reset_request_reg;
    logic       lan_wake_enable_reg;
    logic       phy_irq_wake_enable_reg;
    logic [1:0] wake_cause_status_reg;
    logic       energy_eff_wake_status_reg;
    logic [1:0] susp_reg;
    logic       ready_reg;
    logic       res_clr_en_reg;
    logic       res_clr_sts_reg;
    logic       skip_analog_ref_wait_reg;
    logic       crystal_suspend_disable_reg;
    logic       image_xtal_reg;
    logic       remote_resume;
    logic       start_req;
    logic [31:0] rdata_next;
    logic [31:0] rdata_reg;
    logic       phy_reset_reg;

    phy_reset_request_if pr ();

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    avmm_slave u_bus (
        .clk         (CLK),
        .rst         (RST),
        .address     (AVS_ADDRESS),
        .read        (AVS_READ),
        .write       (AVS_WRITE),
        .waitrequest (waitrequest),
        .wr_stb      (wr_stb),
        .rd_stb      ()
    );

    assign wd      = AVS_WRITEDATA;
    assign ctrl_wr = wr_stb && AVS_ADDRESS == `PMC_OFF_CTRL;
    assign cfg_wr  = wr_stb && AVS_ADDRESS == `PMC_OFF_CFG;
    assign remote_resume = RESUME_DONE && RESUME_REMOTE;

    // ------------------------------------------------------------
    // phy reset
    // ------------------------------------------------------------
    assign start_req = ctrl_wr && wd[`PMC_B_PHY_RESET_REQUEST]
                       && !phy_reset_request_reg;
    // the timer starts only on an accepted write, so the pin never glitches
    assign pr.start     = start_req;
    assign pr.long_hold = !skip_analog_ref_wait_reg;
    assign pr.phy_ready = PHY_OPERATIONAL;

    phy_reset_request_timer #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_tmr (
        .clk (CLK),
        .rst (RST),
        .pr  (pr)
    );

    always_ff @(posedge CLK) begin
        if (RST) begin
            phy_reset_request_reg <= 1'b0;
        end else if (start_req) begin
            phy_reset_request_reg <= 1'b1;
        end else if (pr.done) begin
            phy_reset_request_reg <= 1'b0;
        end
    end

    // reset pin follows the request until the hold completes
    always_ff @(posedge CLK) begin
        if (RST) begin
            phy_reset_reg <= 1'b0;
        end else if (start_req) begin
            phy_reset_reg <= 1'b1;
        end else if (pr.busy) begin
            phy_reset_reg <= 1'b1;
        end else begin
            phy_reset_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ready_reg <= 1'b0;
        end else if (start_req) begin
            ready_reg <= 1'b0;
        end else if (!phy_reset_request_reg && PHY_OPERATIONAL) begin
            ready_reg <= 1'b1;
        end else if (pr.done) begin
            ready_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // wake enables
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            lan_wake_enable_reg     <= 1'b0;
            phy_irq_wake_enable_reg <= 1'b0;
        end else if (remote_resume && res_clr_en_reg) begin
            lan_wake_enable_reg     <= 1'b0;
            phy_irq_wake_enable_reg <= 1'b0;
        end else if (ctrl_wr) begin
            lan_wake_enable_reg     <= wd[`PMC_B_LAN_WAKE_EN];
            phy_irq_wake_enable_reg <= wd[`PMC_B_PHY_IRQ_WAKE_ENABLE];
        end
    end

    // ------------------------------------------------------------
    // wake status: set beats clear
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_cause_status_reg <= 2'h0;
        end else begin
            // bits update independently so both may be set
            if (PHY_WAKE_EVT && phy_irq_wake_enable_reg) begin
                wake_cause_status_reg[0] <= 1'b1;
            end else if (ctrl_wr && wd[`PMC_B_WAKE_LO]) begin
                wake_cause_status_reg[0] <= 1'b0;
            end
            if (LAN_WAKE_EVT && lan_wake_enable_reg) begin
                wake_cause_status_reg[1] <= 1'b1;
            end else if (remote_resume && res_clr_sts_reg) begin
                wake_cause_status_reg[1] <= 1'b0;
            end else if (ctrl_wr && wd[`PMC_B_WAKE_HI]) begin
                wake_cause_status_reg[1] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            energy_eff_wake_status_reg <= 1'b0;
        end else if ((ENERGY_EFF_RX_WAKE && (susp_reg == pm_ctl_pkg::SUSP0
                     || susp_reg == pm_ctl_pkg::SUSP3))
                     || (ENERGY_EFF_TX_WAKE
                     && susp_reg == pm_ctl_pkg::SUSP3)) begin
            energy_eff_wake_status_reg <= 1'b1;
        end else if (remote_resume && res_clr_sts_reg) begin
            energy_eff_wake_status_reg <= 1'b0;
        end else if (ctrl_wr && wd[`PMC_B_ENERGY_EFF_WAKE_STATUS]) begin
            energy_eff_wake_status_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // mode and configuration
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            susp_reg        <= `PMC_RST_SUSP;
            res_clr_en_reg  <= `PMC_RST_RES_CLR_EN;
            res_clr_sts_reg <= 1'b0;
        end else if (ctrl_wr) begin
            // software keeps status clears apart from mode changes
            susp_reg <= wd[`PMC_B_SUSP_HI:`PMC_B_SUSP_LO];
            res_clr_en_reg  <= wd[`PMC_B_RES_CLR_EN];
            res_clr_sts_reg <= wd[`PMC_B_RES_CLR_STS];
        end
    end

    // image value is caught by a clocked process; reset loads the default only while no image is valid
    always_ff @(posedge CLK) begin
        if (IMAGE_VALID) begin
            image_xtal_reg <= IMAGE_XTAL_DIS;
        end else if (RST) begin
            image_xtal_reg <= `PMC_RST_XTAL_DIS;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            skip_analog_ref_wait_reg    <= 1'b0;
            crystal_suspend_disable_reg <= `PMC_RST_XTAL_DIS;
        end else if (USB_RESET || LITE_SOFT_RESET) begin
            crystal_suspend_disable_reg <= image_xtal_reg;
        end else if (cfg_wr) begin
            skip_analog_ref_wait_reg    <= wd[`PMC_B_SKIP_ANA];
            crystal_suspend_disable_reg <= wd[`PMC_B_XTAL_DIS];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0;
        if (AVS_ADDRESS == `PMC_OFF_CTRL) begin
            rdata_next[`PMC_B_WAKE_HI:`PMC_B_WAKE_LO] = wake_cause_status_reg;
            rdata_next[`PMC_B_PHY_IRQ_WAKE_ENABLE] = phy_irq_wake_enable_reg;
            rdata_next[`PMC_B_LAN_WAKE_EN] = lan_wake_enable_reg;
            rdata_next[`PMC_B_PHY_RESET_REQUEST]     = phy_reset_request_reg;
            rdata_next[`PMC_B_SUSP_HI:`PMC_B_SUSP_LO] = susp_reg;
            rdata_next[`PMC_B_READY]       = ready_reg;
            rdata_next[`PMC_B_RES_CLR_EN]  = res_clr_en_reg;
            rdata_next[`PMC_B_RES_CLR_STS] = res_clr_sts_reg;
            rdata_next[`PMC_B_ENERGY_EFF_WAKE_STATUS]    = energy_eff_wake_status_reg;
        end else if (AVS_ADDRESS == `PMC_OFF_CFG) begin
            rdata_next[`PMC_B_SKIP_ANA] = skip_analog_ref_wait_reg;
            rdata_next[`PMC_B_XTAL_DIS] = crystal_suspend_disable_reg;
        end
    end

    // data registered in the wait cycle so it stands at the ack edge
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_reg       <= 32'h0;
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            // zero outside the answer cycle keeps stale data off the bus
            rdata_reg       <= (AVS_READ && waitrequest) ? rdata_next : 32'h0;
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && waitrequest);
        end
    end

    assign AVS_READDATA = rdata_reg;

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    assign PHY_RESET               = phy_reset_reg;
    assign DEVICE_READY            = ready_reg;
    assign SUSPEND_SEL             = susp_reg;
    assign LAN_WAKE_ARMED          = lan_wake_enable_reg;
    assign PHY_WAKE_ARMED          = phy_irq_wake_enable_reg;
    assign CRYSTAL_SUSPEND_DISABLE = crystal_suspend_disable_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence req_set_s;
        start_req;
    endsequence

    start_a: assert property (
        @(posedge CLK) disable iff (RST)
        req_set_s |=> phy_reset_request_reg && PHY_RESET)
        else $error("phy reset not started");
    selfclr_a: assert property (
        @(posedge CLK) disable iff (RST)
        pr.done |=> !phy_reset_request_reg)
        else $error("request did not self-clear");
    ignore_wr_a: assert property (
        @(posedge CLK) disable iff (RST)
        phy_reset_request_reg && !pr.done |=> phy_reset_request_reg)
        else $error("request changed while high");
    ready_drop_a: assert property (
        @(posedge CLK) disable iff (RST)
        req_set_s |=> !DEVICE_READY)
        else $error("ready stayed high on request");
    ready_low_a: assert property (
        @(posedge CLK) disable iff (RST)
        phy_reset_request_reg |-> !DEVICE_READY)
        else $error("ready high during phy reset");
    ready_back_a: assert property (
        @(posedge CLK) disable iff (RST)
        pr.done |=> DEVICE_READY)
        else $error("ready not restored after phy reset");
    hold_pin_a: assert property (
        @(posedge CLK) disable iff (RST)
        pr.busy |-> PHY_RESET)
        else $error("phy reset pin low during hold");
    enables_clr_a: assert property (
        @(posedge CLK) disable iff (RST)
        remote_resume && res_clr_en_reg |=> !LAN_WAKE_ARMED && !PHY_WAKE_ARMED)
        else $error("enables survived remote resume");
    no_enable_a: assert property (
        @(posedge CLK) disable iff (RST)
        !phy_irq_wake_enable_reg && !wake_cause_status_reg[0]
        |=> !wake_cause_status_reg[0])
        else $error("status set without enable");
    lan_quiet_a: assert property (
        @(posedge CLK) disable iff (RST)
        !lan_wake_enable_reg && !wake_cause_status_reg[1]
        |=> !wake_cause_status_reg[1])
        else $error("lan status set without enable");
    w1c_a: assert property (
        @(posedge CLK) disable iff (RST)
        ctrl_wr && wd[`PMC_B_WAKE_LO] && !PHY_WAKE_EVT
        |=> !wake_cause_status_reg[0])
        else $error("status not cleared by write one");
    eee_set_a: assert property (
        @(posedge CLK) disable iff (RST)
        ENERGY_EFF_TX_WAKE && susp_reg == pm_ctl_pkg::SUSP3
        |=> energy_eff_wake_status_reg)
        else $error("energy wake status not set");
endmodule : pm_ctl

// File: inc/pm_ctl_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PM_CTL_REGS_SVH
`define PM_CTL_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PMC_ADDR_W            4
`define PMC_OFF_CTRL          4'h0
`define PMC_OFF_CFG           4'h4

// ----------------------------------------------------------------
// power_mgmt_control fields
// ----------------------------------------------------------------
`define PMC_B_WAKE_LO         0
`define PMC_B_WAKE_HI         1
`define PMC_B_PHY_IRQ_WAKE_ENABLE     2
`define PMC_B_LAN_WAKE_EN     3
`define PMC_B_PHY_RESET_REQUEST         4
`define PMC_B_SUSP_LO         5
`define PMC_B_SUSP_HI         6
`define PMC_B_READY           7
`define PMC_B_RES_CLR_EN      8
`define PMC_B_RES_CLR_STS     9
`define PMC_B_ENERGY_EFF_WAKE_STATUS        12

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define PMC_B_SKIP_ANA        0
`define PMC_B_XTAL_DIS        1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMC_RST_SUSP          2'h2
`define PMC_RST_RES_CLR_EN    1'h1
`define PMC_RST_XTAL_DIS      1'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMC_CLK_MHZ           100
`define PMC_PHY_RESET_REQUEST_MIN_MS    4
`define PMC_PHY_RESET_REQUEST_LONG_MS   128
`define PMC_MS_CYCLES(ms)     ((ms) * 1000 * `PMC_CLK_MHZ)

`endif

// File: inc/pm_ctl_pkg.sv
// types shared by the power management control block
package pm_ctl_pkg;
    typedef enum logic [1:0] {
        SUSP0,
        SUSP1,
        SUSP2,
        SUSP3
    } susp_t;

    typedef enum {
        RST_IDLE,
        RST_HOLD,
        RST_SETTLE
    } rst_state_t;
endpackage : pm_ctl_pkg

// File: inc/phy_reset_request_if.sv
// handshake between the control register and the phy reset timer
interface phy_reset_request_if;
    logic start;
    logic long_hold;
    logic phy_ready;
    logic busy;
    logic done;

    modport ctl (output start, output long_hold, input phy_ready,
                 input busy, input done);
    modport tmr (input start, input long_hold, input phy_ready,
                 output busy, output done);
endinterface : phy_reset_request_if

// File: hw/phy_reset_request_timer.sv
// self-timed phy reset hold counter
`include "pm_ctl_regs.svh"
module phy_reset_request_timer #(
    parameter int SHORT_CYC = `PMC_MS_CYCLES(`PMC_PHY_RESET_REQUEST_MIN_MS),
    parameter int LONG_CYC  = `PMC_MS_CYCLES(`PMC_PHY_RESET_REQUEST_LONG_MS)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control side
    phy_reset_request_if.tmr   pr
);
    pm_ctl_pkg::rst_state_t state_reg;
    logic [31:0]            cnt_reg;
    logic [31:0]            target;

    assign target = pr.long_hold ? LONG_CYC : SHORT_CYC;

    // --------------------------------------------------------------
    // hold sequencer
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= pm_ctl_pkg::RST_IDLE;
            cnt_reg   <= 32'h0;
        end else begin
            unique case (state_reg)
                pm_ctl_pkg::RST_IDLE: begin
                    cnt_reg <= 32'h0;
                    if (pr.start) begin
                        state_reg <= pm_ctl_pkg::RST_HOLD;
                    end
                end
                pm_ctl_pkg::RST_HOLD: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg >= target - 32'h1) begin
                        state_reg <= pm_ctl_pkg::RST_SETTLE;
                    end
                end
                pm_ctl_pkg::RST_SETTLE: begin
                    if (pr.phy_ready) begin
                        state_reg <= pm_ctl_pkg::RST_IDLE;
                    end
                end
            endcase
        end
    end

    assign pr.busy = state_reg == pm_ctl_pkg::RST_HOLD;
    assign pr.done = state_reg == pm_ctl_pkg::RST_SETTLE && pr.phy_ready;

    hold_len_a: assert property (
        @(posedge clk) disable iff (rst) $rose(pr.busy) |-> pr.busy[*8])
        else $error("phy reset hold ended early");
endmodule : phy_reset_request_timer

// File: hw/avmm_slave.sv
// avalon-mm slave front end with one wait state on every access
`include "pm_ctl_regs.svh"
module avmm_slave (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // bus
    input  wire logic [`PMC_ADDR_W-1:0] address,
    input  wire logic                   read,
    input  wire logic                   write,
    output logic                        waitrequest,
    // register side
    output logic                        wr_stb,
    output logic                        rd_stb
);
    logic ack_reg;

    // one wait cycle, then a single-cycle acknowledge
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read || write) && !ack_reg;
        end
    end

    assign waitrequest = !ack_reg;
    assign wr_stb      = write && ack_reg;
    assign rd_stb      = read && ack_reg;
endmodule : avmm_slave

// File: dv/phy_model.sv
// phy side model: operational only some cycles after its reset is released
module phy_model #(
    parameter int READY_DLY = 5
) (
    // clock
    input  wire logic clk,
    // phy pins
    input  wire logic phy_reset,
    output logic      phy_operational
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt_reg = 0;
    logic op_reg  = 1'b0;
    // ----------------------------------------------------------------
    // power-up delay after release
    // ----------------------------------------------------------------
    // no early ready: a real phy needs time after reset before it works
    always @(posedge clk) begin
        if (phy_reset === 1'b1) begin
            cnt_reg <= 0;
            op_reg  <= 1'b0;
        end else if (cnt_reg < READY_DLY) begin
            cnt_reg <= cnt_reg + 1;
        end else begin
            op_reg <= 1'b1;
        end
    end
    assign phy_operational = op_reg;
endmodule : phy_model

// File: dv/test_phy_reset_and_wake_status.sv
// register-level bench for the power management control block
`include "pm_ctl_regs.svh"
module test_phy_reset_and_wake_status;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 20;
    localparam int LC = 40;
    logic        clk, rst, rd_en, wr_en, remote, xtal, phy_op;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [7:0]  ev;
    logic        wreq, phy_reset_request, rdy, lan_arm, phy_arm, xtal_out;
    logic [1:0]  susp;
    int          failures, tests_run, cyc, hold;
    pm_ctl #(.SHORT_CYC(SC), .LONG_CYC(LC)) pm_ctl_inst (
        .CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wreq), .PHY_RESET(phy_reset_request),
        .PHY_OPERATIONAL(phy_op), .PHY_WAKE_EVT(ev[0]),
        .LAN_WAKE_EVT(ev[1]), .ENERGY_EFF_RX_WAKE(ev[2]),
        .ENERGY_EFF_TX_WAKE(ev[3]), .RESUME_DONE(ev[4]),
        .RESUME_REMOTE(remote), .LITE_SOFT_RESET(ev[5]),
        .USB_RESET(ev[6]), .IMAGE_VALID(ev[7]), .IMAGE_XTAL_DIS(xtal),
        .SUSPEND_SEL(susp), .DEVICE_READY(rdy), .LAN_WAKE_ARMED(lan_arm),
        .PHY_WAKE_ARMED(phy_arm), .CRYSTAL_SUSPEND_DISABLE(xtal_out));
    phy_model #(.READY_DLY(5)) phy_model_inst (
        .clk(clk), .phy_reset(phy_reset_request), .phy_operational(phy_op));
    // ----------------------------------------------------------------
    // clock, timeout and reset-length monitor
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (phy_reset_request === 1'b1) hold++;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until waitrequest is seen low at a rising edge;
    // outputs are looked at afterwards, settled, at the falling edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wr_en <= w;
        rd_en <= ~w;
        wdata <= d;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(negedge clk);
    endtask : bus
    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 8'h00;
        @(negedge clk);
    endtask : pulse
    task automatic phyrst(input logic skip, input int lo, input int hi);
        int n, h0;
        bus(1'b1, `PMC_OFF_CFG, {30'h0, 1'b1, skip});
        h0 = hold;
        bus(1'b1, `PMC_OFF_CTRL, 32'h150);
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'h90, 32'h10);
        chk({31'h0, phy_reset_request}, 32'h1);
        bus(1'b1, `PMC_OFF_CTRL, 32'h140);
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'h10, 32'h10);
        for (n = 0; n < 300 && q[4] !== 1'b0; n++)
            bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk({31'h0, phy_reset_request}, 32'h0);
        n = hold - h0;
        chk({31'h0, n >= lo && n < hi}, 32'h1);
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'h90, 32'h80);
        chk({31'h0, rdy}, 32'h1);
    endtask : phyrst
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rd_en, wr_en, remote, xtal} = 4'h0;
        addr = 4'h0;
        wdata = 32'h0;
        ev = 8'h00;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'hffffff7f, 32'h140);
        bus(1'b0, `PMC_OFF_CFG, 32'h0);
        chk(q, 32'h2);
        bus(1'b1, 4'h8, 32'hffffffff);
        bus(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0);
        phyrst(1'b1, SC, LC);
        phyrst(1'b0, LC, 1000);
        bus(1'b1, `PMC_OFF_CTRL, 32'h14c);
        chk({30'h0, lan_arm, phy_arm}, 32'h3);
        pulse(8'h03);
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'h3, 32'h3);
        bus(1'b1, `PMC_OFF_CTRL, 32'h14d);
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'h100f, 32'he);
        bus(1'b1, `PMC_OFF_CTRL, 32'h14e);
        pulse(8'h01);
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'h3, 32'h1);
        bus(1'b1, `PMC_OFF_CTRL, 32'h141);
        pulse(8'h03);
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'h3, 32'h0);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, `PMC_OFF_CTRL, 32'h100 | (s << 5));
            chk({30'h0, susp}, s);
            pulse((s == 3) ? 8'h08 : 8'h0c);
            bus(1'b0, `PMC_OFF_CTRL, 32'h0);
            chk(q & 32'h1000, (s % 3 == 0) ? 32'h1000 : 32'h0);
            bus(1'b1, `PMC_OFF_CTRL, 32'h1100 | (s << 5));
            bus(1'b0, `PMC_OFF_CTRL, 32'h0);
            chk(q & 32'h1000, 32'h0);
        end
        bus(1'b1, `PMC_OFF_CTRL, 32'h34c);
        pulse(8'h03);
        pulse(8'h10);
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'hf, 32'hf);
        @(posedge clk) remote <= 1'b1;
        pulse(8'h10);
        @(posedge clk) remote <= 1'b0;
        bus(1'b0, `PMC_OFF_CTRL, 32'h0);
        chk(q & 32'hf, 32'h1);
        chk({30'h0, lan_arm, phy_arm}, 32'h0);
        bus(1'b1, `PMC_OFF_CTRL, 32'h341);
        phyrst(1'b1, SC, LC);
        pulse(8'h80);
        bus(1'b1, `PMC_OFF_CFG, 32'h3);
        pulse(8'h40);
        bus(1'b0, `PMC_OFF_CFG, 32'h0);
        chk(q & 32'h2, 32'h0);
        chk({31'h0, xtal_out}, 32'h0);
        bus(1'b1, `PMC_OFF_CFG, 32'h3);
        pulse(8'h20);
        bus(1'b0, `PMC_OFF_CFG, 32'h0);
        chk(q & 32'h2, 32'h0);
        @(posedge clk) xtal <= 1'b1;
        pulse(8'h80);
        bus(1'b1, `PMC_OFF_CFG, 32'h0);
        pulse(8'h40);
        bus(1'b0, `PMC_OFF_CFG, 32'h0);
        chk(q & 32'h2, 32'h2);
        give_verdict();
    end
endmodule : test_phy_reset_and_wake_status
